// ### shared/io_space_consts.vh
// Purpose: constants for the lower I/O register space decoder
// Assumes: 8-bit data, 6-bit I/O numbers, 8-bit data-space addresses
// Notes: offsets are I/O numbers; data-space address adds the window base
`ifndef IO_SPACE_CONSTS_VH
`define IO_SPACE_CONSTS_VH

`define IO_DATA_BASE 8'h20
`define IO_DATA_TOP 8'h5F
`define IO_BIT_TOP 6'h1F
`define EXT_IO_LOW 8'h60
`define EXT_IO_HIGH 8'hFF

`define OFF_PORT_A_IN 6'h00
`define OFF_PORT_A_DIR 6'h01
`define OFF_PORT_A_OUT 6'h02
`define OFF_PORT_B_IN 6'h03
`define OFF_PORT_B_DIR 6'h04
`define OFF_PORT_B_OUT 6'h05
`define OFF_PORT_C_OUT 6'h08
`define OFF_PORT_D_IN 6'h09
`define OFF_PORT_D_DIR 6'h0A
`define OFF_PORT_D_OUT 6'h0B
`define OFF_T0_FLAGS 6'h15
`define OFF_T1_FLAGS 6'h16
`define OFF_PC_FLAGS 6'h1B
`define OFF_EXT_FLAGS 6'h1C
`define OFF_EXT_MASK 6'h1D
`define OFF_SCRATCH0 6'h1E
`define OFF_EE_CONTROL 6'h1F
`define OFF_EE_DATA 6'h20
`define OFF_EE_ADDR_LO 6'h21
`define OFF_EE_ADDR_HI 6'h22
`define OFF_TIMER_GLOBAL 6'h23
`define OFF_T0_CTRL_A 6'h24
`define OFF_T0_CTRL_B 6'h25
`define OFF_T0_COUNT 6'h26
`define OFF_T0_CMP_A 6'h27
`define OFF_T0_CMP_B 6'h28
`define OFF_SCRATCH1 6'h2A
`define OFF_SCRATCH2 6'h2B

// Implemented bit masks; other bits read zero and ignore writes
`define MASK_FULL 8'hFF
`define MASK_PORT_C 8'h01
`define MASK_PORT_D 8'h03
`define MASK_T0_FLAGS 8'h07
`define MASK_T1_FLAGS 8'h03
`define MASK_PC_FLAGS 8'h03
`define MASK_EXT4 8'h0F
`define MASK_EE_CONTROL 8'h3F
`define MASK_EE_ADDR_HI 8'h01
`define MASK_TIMER_GLOBAL 8'h81
`define MASK_T0_CTRL_A 8'hF3
`define MASK_T0_CTRL_B 8'hCF

// Timer 0 flag positions
`define T0_OVERFLOW_BIT 0
`define T0_MATCH_A_BIT 1
`define T0_MATCH_B_BIT 2

// Operation codes from the core
`define OP_NONE 3'h0
`define OP_IO_READ 3'h1
`define OP_IO_WRITE 3'h2
`define OP_DATA_READ 3'h3
`define OP_DATA_WRITE 3'h4
`define OP_SET_BIT 3'h5
`define OP_CLEAR_BIT 3'h6
`define OP_SKIP_TEST 3'h7

`define RESET_BYTE 8'h00

`endif

// ### design/io_space_register_decoder.v
// Purpose: lower I/O register space decoder with bit access and W1C flags
// Assumes: one core operation per cycle, results one cycle later
// Notes: data-space window 0x20..0x5F maps to I/O 0x00..0x3F
// Contract
// (RQ1) Bit set/clear modifies I/O 0x00-0x1F
// (RQ2) Skip tests one bit in low range
// (RQ3) Status flags clear on written one
// (RQ4) Bit ops are whole-register read-modify-write
// (RQ5) Bit ops ignored above I/O 0x1F
// (RQ6) In/out instructions address I/O 0x00-0x3F
// (RQ7) Data address equals I/O plus 0x20
// (RQ8) Extended 0x60-0xFF only via load/store
// (RQ9) Software writes zero to reserved bits
// (RQ10) Software never writes reserved addresses
// (RQ11) Ports: input, direction, output consecutive
// (RQ12) Timer0 flags: overflow, match A, B
// (RQ13) Reserved reads zero, writes ignored
`timescale 1ns/1ps
`include "io_space_consts.vh"

module io_space_register_decoder (
  input wire clock,
  input wire rst,
  input wire [2:0] op,
  input wire [5:0] io_addr,
  input wire [7:0] data_addr,
  input wire [2:0] bit_sel,
  input wire [7:0] wdata,
  input wire [7:0] port_a_pins,
  input wire [7:0] port_b_pins,
  input wire [1:0] port_d_pins,
  input wire [2:0] t0_events,
  input wire [1:0] t1_events,
  input wire [1:0] pin_change_events,
  input wire [3:0] ext_irq_events,
  output reg [7:0] rdata,
  output reg rvalid,
  output reg bit_value,
  output reg ext_access,
  output reg [7:0] ext_addr,
  output reg [7:0] port_a_direction,
  output reg [7:0] port_a_output,
  output reg [7:0] port_b_direction,
  output reg [7:0] port_b_output,
  output reg [7:0] port_c_output,
  output reg [7:0] port_d_direction,
  output reg [7:0] port_d_output,
  output reg [7:0] timer0_flags,
  output reg [7:0] timer1_flags,
  output reg [7:0] pin_change_flags,
  output reg [7:0] external_irq_flags,
  output reg [7:0] external_irq_mask,
  output reg [7:0] eeprom_control,
  output reg [7:0] eeprom_data,
  output reg [7:0] eeprom_address_low,
  output reg [7:0] eeprom_address_high,
  output reg [7:0] timer_global_control,
  output reg [7:0] timer0_control_a,
  output reg [7:0] timer0_control_b,
  output reg [7:0] timer0_count,
  output reg [7:0] timer0_compare_a,
  output reg [7:0] timer0_compare_b,
  output reg [7:0] scratch_reg_0,
  output reg [7:0] scratch_reg_1,
  output reg [7:0] scratch_reg_2
);

  // Pin synchronisers; first stage read only by second stage
  reg [7:0] a_meta;
  reg [7:0] a_sync;
  reg [7:0] b_meta;
  reg [7:0] b_sync;
  reg [1:0] d_meta;
  reg [1:0] d_sync;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      a_meta <= `RESET_BYTE;
      a_sync <= `RESET_BYTE;
      b_meta <= `RESET_BYTE;
      b_sync <= `RESET_BYTE;
      d_meta <= 2'b00;
      d_sync <= 2'b00;
    end else begin
      a_meta <= port_a_pins;
      a_sync <= a_meta;
      b_meta <= port_b_pins;
      b_sync <= b_meta;
      d_meta <= port_d_pins;
      d_sync <= d_meta;
    end
  end

  // Data-space offset into the window; all eight bits are kept, only the low six are used
  wire [7:0] data_offset = data_addr - `IO_DATA_BASE;

  // Address translation for the two views
  reg [5:0] sel;
  reg in_window;
  reg is_ext;
  reg is_read;
  reg is_write;
  reg is_bitop;
  always @* begin
    sel = io_addr;
    in_window = 1'b0;
    is_ext = 1'b0;
    is_read = 1'b0;
    is_write = 1'b0;
    is_bitop = 1'b0;
    if (op == `OP_IO_READ || op == `OP_IO_WRITE) begin
      in_window = 1'b1; // RQ6
      is_read = (op == `OP_IO_READ);
      is_write = (op == `OP_IO_WRITE);
    end else if (op == `OP_DATA_READ || op == `OP_DATA_WRITE) begin
      // Below the window sit core registers, which live elsewhere
      if (data_addr >= `IO_DATA_BASE && data_addr <= `IO_DATA_TOP) begin
        sel = data_offset[5:0]; // RQ7
        in_window = 1'b1;
        is_read = (op == `OP_DATA_READ);
        is_write = (op == `OP_DATA_WRITE);
      end else if (data_addr >= `EXT_IO_LOW) begin
        is_ext = 1'b1; // RQ8
      end
    end else if (op == `OP_SET_BIT || op == `OP_CLEAR_BIT || op == `OP_SKIP_TEST) begin
      // Bit ops outside the low range do nothing
      if (io_addr <= `IO_BIT_TOP) begin
        in_window = 1'b1; // RQ5
        is_bitop = 1'b1;
        is_read = (op == `OP_SKIP_TEST);
      end
    end
  end

  // Read mux; reserved addresses and bits read zero
  reg [7:0] cur;
  always @* begin
    cur = `RESET_BYTE;
    if (sel == `OFF_PORT_A_IN) cur = a_sync; // RQ11
    else if (sel == `OFF_PORT_A_DIR) cur = port_a_direction;
    else if (sel == `OFF_PORT_A_OUT) cur = port_a_output;
    else if (sel == `OFF_PORT_B_IN) cur = b_sync;
    else if (sel == `OFF_PORT_B_DIR) cur = port_b_direction;
    else if (sel == `OFF_PORT_B_OUT) cur = port_b_output;
    else if (sel == `OFF_PORT_C_OUT) cur = port_c_output;
    else if (sel == `OFF_PORT_D_IN) cur = {6'b000000, d_sync};
    else if (sel == `OFF_PORT_D_DIR) cur = port_d_direction;
    else if (sel == `OFF_PORT_D_OUT) cur = port_d_output;
    else if (sel == `OFF_T0_FLAGS) cur = timer0_flags;
    else if (sel == `OFF_T1_FLAGS) cur = timer1_flags;
    else if (sel == `OFF_PC_FLAGS) cur = pin_change_flags;
    else if (sel == `OFF_EXT_FLAGS) cur = external_irq_flags;
    else if (sel == `OFF_EXT_MASK) cur = external_irq_mask;
    else if (sel == `OFF_SCRATCH0) cur = scratch_reg_0;
    else if (sel == `OFF_EE_CONTROL) cur = eeprom_control;
    else if (sel == `OFF_EE_DATA) cur = eeprom_data;
    else if (sel == `OFF_EE_ADDR_LO) cur = eeprom_address_low;
    else if (sel == `OFF_EE_ADDR_HI) cur = eeprom_address_high;
    else if (sel == `OFF_TIMER_GLOBAL) cur = timer_global_control;
    else if (sel == `OFF_T0_CTRL_A) cur = timer0_control_a;
    else if (sel == `OFF_T0_CTRL_B) cur = timer0_control_b;
    else if (sel == `OFF_T0_COUNT) cur = timer0_count;
    else if (sel == `OFF_T0_CMP_A) cur = timer0_compare_a;
    else if (sel == `OFF_T0_CMP_B) cur = timer0_compare_b;
    else if (sel == `OFF_SCRATCH1) cur = scratch_reg_1;
    else if (sel == `OFF_SCRATCH2) cur = scratch_reg_2;
    else cur = `RESET_BYTE; // RQ13
  end

  // Hazard: a set-bit op on a flag register clears every flag read as one; a clear-bit op clears all of them except the selected bit
  // Write value; bit ops write back the whole read value
  reg [7:0] wval;
  reg do_write;
  always @* begin
    wval = wdata;
    do_write = is_write;
    if (is_bitop && op == `OP_SET_BIT) begin
      wval = cur | (8'h01 << bit_sel); // RQ1 RQ4
      do_write = 1'b1;
    end else if (is_bitop && op == `OP_CLEAR_BIT) begin
      wval = cur & ~(8'h01 << bit_sel); // RQ1 RQ4
      do_write = 1'b1;
    end
  end

  // Per-address write strobes; unknown addresses raise none
  wire wr_hit_a_dir = do_write && (sel == `OFF_PORT_A_DIR);
  wire wr_hit_a_out = do_write && (sel == `OFF_PORT_A_OUT);
  wire wr_hit_b_dir = do_write && (sel == `OFF_PORT_B_DIR);
  wire wr_hit_b_out = do_write && (sel == `OFF_PORT_B_OUT);
  wire wr_hit_c_out = do_write && (sel == `OFF_PORT_C_OUT);
  wire wr_hit_d_dir = do_write && (sel == `OFF_PORT_D_DIR);
  wire wr_hit_d_out = do_write && (sel == `OFF_PORT_D_OUT);
  wire wr_hit_ext_mask = do_write && (sel == `OFF_EXT_MASK);
  wire wr_hit_scratch0 = do_write && (sel == `OFF_SCRATCH0);
  wire wr_hit_ee_control = do_write && (sel == `OFF_EE_CONTROL);
  wire wr_hit_ee_data = do_write && (sel == `OFF_EE_DATA);
  wire wr_hit_ee_addr_lo = do_write && (sel == `OFF_EE_ADDR_LO);
  wire wr_hit_ee_addr_hi = do_write && (sel == `OFF_EE_ADDR_HI);
  wire wr_hit_timer_global = do_write && (sel == `OFF_TIMER_GLOBAL);
  wire wr_hit_t0_ctrl_a = do_write && (sel == `OFF_T0_CTRL_A);
  wire wr_hit_t0_ctrl_b = do_write && (sel == `OFF_T0_CTRL_B);
  wire wr_hit_t0_count = do_write && (sel == `OFF_T0_COUNT);
  wire wr_hit_t0_cmp_a = do_write && (sel == `OFF_T0_CMP_A);
  wire wr_hit_t0_cmp_b = do_write && (sel == `OFF_T0_CMP_B);
  wire wr_hit_scratch1 = do_write && (sel == `OFF_SCRATCH1);
  wire wr_hit_scratch2 = do_write && (sel == `OFF_SCRATCH2);
  wire wr_hit_t0_flags = do_write && (sel == `OFF_T0_FLAGS);
  wire wr_hit_t1_flags = do_write && (sel == `OFF_T1_FLAGS);
  wire wr_hit_pc_flags = do_write && (sel == `OFF_PC_FLAGS);
  wire wr_hit_ext_flags = do_write && (sel == `OFF_EXT_FLAGS);

  // Clear masks: the written byte, or nothing when not addressed
  wire [7:0] clr_t0 = wr_hit_t0_flags ? wval : 8'h00;
  wire [7:0] clr_t1 = wr_hit_t1_flags ? wval : 8'h00;
  wire [7:0] clr_pc = wr_hit_pc_flags ? wval : 8'h00;
  wire [7:0] clr_ext = wr_hit_ext_flags ? wval : 8'h00;

  // Event pulses widened to a byte; unused positions stay low
  wire [7:0] t0_set = {5'b00000, t0_events};
  wire [7:0] t1_set = {6'b000000, t1_events};
  wire [7:0] pc_set = {6'b000000, pin_change_events};
  wire [7:0] ext_set = {4'b0000, ext_irq_events};

  // Implemented flag positions; reserved ones can never be set
  wire [7:0] t0_mask = `MASK_T0_FLAGS;
  wire [7:0] t1_mask = `MASK_T1_FLAGS;
  wire [7:0] pc_mask = `MASK_PC_FLAGS;
  wire [7:0] ext_mask = `MASK_EXT4;

  // Next flag values, one bit at a time for all four registers
  wire [7:0] next_timer0_flags;
  wire [7:0] next_timer1_flags;
  wire [7:0] next_pin_change_flags;
  wire [7:0] next_external_irq_flags;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag_bit
      // Event term is ORed last, so a set in the clear cycle wins
      assign next_timer0_flags[i] = ((timer0_flags[i] & ~clr_t0[i]) | t0_set[i]) & t0_mask[i]; // RQ3 RQ12
      assign next_timer1_flags[i] = ((timer1_flags[i] & ~clr_t1[i]) | t1_set[i]) & t1_mask[i]; // RQ3
      assign next_pin_change_flags[i] = ((pin_change_flags[i] & ~clr_pc[i]) | pc_set[i]) & pc_mask[i]; // RQ3
      assign next_external_irq_flags[i] = ((external_irq_flags[i] & ~clr_ext[i]) | ext_set[i]) & ext_mask[i]; // RQ3
    end
  endgenerate

  // Sticky flags
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timer0_flags <= `RESET_BYTE;
      timer1_flags <= `RESET_BYTE;
      pin_change_flags <= `RESET_BYTE;
      external_irq_flags <= `RESET_BYTE;
    end else begin
      timer0_flags <= next_timer0_flags;
      timer1_flags <= next_timer1_flags;
      pin_change_flags <= next_pin_change_flags;
      external_irq_flags <= next_external_irq_flags;
    end
  end

  // Plain read/write registers, masked to implemented bits
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      port_a_direction <= `RESET_BYTE;
      port_a_output <= `RESET_BYTE;
      port_b_direction <= `RESET_BYTE;
      port_b_output <= `RESET_BYTE;
      port_c_output <= `RESET_BYTE;
      port_d_direction <= `RESET_BYTE;
      port_d_output <= `RESET_BYTE;
      external_irq_mask <= `RESET_BYTE;
      scratch_reg_0 <= `RESET_BYTE;
      eeprom_control <= `RESET_BYTE;
      eeprom_data <= `RESET_BYTE;
      eeprom_address_low <= `RESET_BYTE;
      eeprom_address_high <= `RESET_BYTE;
      timer_global_control <= `RESET_BYTE;
      timer0_control_a <= `RESET_BYTE;
      timer0_control_b <= `RESET_BYTE;
      timer0_count <= `RESET_BYTE;
      timer0_compare_a <= `RESET_BYTE;
      timer0_compare_b <= `RESET_BYTE;
      scratch_reg_1 <= `RESET_BYTE;
      scratch_reg_2 <= `RESET_BYTE;
    end else begin
      if (wr_hit_a_dir) port_a_direction <= wval; // RQ11
      if (wr_hit_a_out) port_a_output <= wval;
      if (wr_hit_b_dir) port_b_direction <= wval;
      if (wr_hit_b_out) port_b_output <= wval;
      if (wr_hit_c_out) port_c_output <= wval & `MASK_PORT_C; // RQ13
      if (wr_hit_d_dir) port_d_direction <= wval & `MASK_PORT_D;
      if (wr_hit_d_out) port_d_output <= wval & `MASK_PORT_D;
      if (wr_hit_ext_mask) external_irq_mask <= wval & `MASK_EXT4;
      if (wr_hit_scratch0) scratch_reg_0 <= wval;
      if (wr_hit_ee_control) eeprom_control <= wval & `MASK_EE_CONTROL;
      if (wr_hit_ee_data) eeprom_data <= wval;
      if (wr_hit_ee_addr_lo) eeprom_address_low <= wval;
      if (wr_hit_ee_addr_hi) eeprom_address_high <= wval & `MASK_EE_ADDR_HI;
      if (wr_hit_timer_global) timer_global_control <= wval & `MASK_TIMER_GLOBAL;
      if (wr_hit_t0_ctrl_a) timer0_control_a <= wval & `MASK_T0_CTRL_A;
      if (wr_hit_t0_ctrl_b) timer0_control_b <= wval & `MASK_T0_CTRL_B;
      if (wr_hit_t0_count) timer0_count <= wval;
      if (wr_hit_t0_cmp_a) timer0_compare_a <= wval;
      if (wr_hit_t0_cmp_b) timer0_compare_b <= wval;
      if (wr_hit_scratch1) scratch_reg_1 <= wval;
      if (wr_hit_scratch2) scratch_reg_2 <= wval;
    end
  end

  // Answer values ahead of the output flops
  reg [7:0] next_rdata;
  reg next_rvalid;
  reg next_bit_value;
  reg next_ext_access;
  reg [7:0] next_ext_addr;
  always @* begin
    next_rvalid = is_read && in_window;
    next_rdata = next_rvalid ? cur : `RESET_BYTE;
    next_bit_value = (op == `OP_SKIP_TEST && is_bitop) ? cur[bit_sel] : 1'b0; // RQ2
    next_ext_access = is_ext; // RQ8
    next_ext_addr = is_ext ? data_addr : `RESET_BYTE;
  end

  // Registered answers; idle cycles show zero, never stale data
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= `RESET_BYTE;
      rvalid <= 1'b0;
      bit_value <= 1'b0;
      ext_access <= 1'b0;
      ext_addr <= `RESET_BYTE;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      bit_value <= next_bit_value;
      ext_access <= next_ext_access;
      ext_addr <= next_ext_addr;
    end
  end

endmodule // io_space_register_decoder

// ### tb/io_space_checker_sva.sv
// Purpose: port assertions for the I/O space decoder
// Assumes: one op per cycle, answers one edge later
// Notes: watches ports only
`timescale 1ns/1ps
module io_space_checker (
  input wire clock,
  input wire rst,
  input wire [2:0] op,
  input wire [5:0] io_addr,
  input wire [7:0] data_addr,
  input wire [2:0] bit_sel,
  input wire [7:0] wdata,
  input wire [2:0] t0_events,
  input wire rvalid,
  input wire bit_value,
  input wire ext_access,
  input wire [7:0] ext_addr,
  input wire [7:0] timer0_flags,
  input wire [7:0] scratch_reg_0
);
  reg [2:0] sel_q;
  // Bit select of the previous op, for checks one edge late
  always @(posedge clock or posedge rst) begin
    if (rst) sel_q <= 3'h0;
    else sel_q <= bit_sel;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rd; op == 3'h1 |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_skp; op == 3'h7 && io_addr == 6'h1E |=> rvalid && bit_value == scratch_reg_0[sel_q]; endproperty
  a_skp: assert property (p_skp) else $error("skip bit wrong");
  property p_hi; op >= 3'h5 && io_addr > 6'h1F |=> !rvalid && !bit_value; endproperty
  a_hi: assert property (p_hi) else $error("bit op above range");
  property p_set; op == 3'h5 && io_addr == 6'h1E |=> scratch_reg_0 == ($past(scratch_reg_0) | (8'h01 << sel_q));
  endproperty
  a_set: assert property (p_set) else $error("bit set wrong");
  property p_ext; (op == 3'h3 || op == 3'h4) && data_addr >= 8'h60 |=> ext_access && ext_addr == $past(data_addr);
  endproperty
  a_ext: assert property (p_ext) else $error("extended access wrong");
  property p_map; op == 3'h4 && data_addr == 8'h3E |=> scratch_reg_0 == $past(wdata); endproperty
  a_map: assert property (p_map) else $error("data map wrong");
  property p_w1c; op == 3'h2 && io_addr == 6'h15 && t0_events == 3'h0
    |=> timer0_flags == ($past(timer0_flags) & ~$past(wdata) & 8'h07); endproperty
  a_w1c: assert property (p_w1c) else $error("flag clear wrong");
  property p_rmw; op == 3'h5 && io_addr == 6'h15 && t0_events == 3'h0 |=> timer0_flags == 8'h00; endproperty
  a_rmw: assert property (p_rmw) else $error("bit set kept flags");
endmodule // io_space_checker
bind io_space_register_decoder io_space_checker io_space_checker_i (.clock, .rst, .op, .io_addr, .data_addr,
  .bit_sel, .wdata, .t0_events, .rvalid, .bit_value, .ext_access, .ext_addr, .timer0_flags, .scratch_reg_0);

// ### tb/core_model.sv
// Purpose: core side issuing I/O and load/store ops
// Assumes: ops driven after a falling edge
// Notes: released lines toggle so stale values never look live
`timescale 1ns/1ps
module core_model (
  input wire clock,
  output reg [2:0] op,
  output reg [5:0] io_addr,
  output reg [7:0] data_addr,
  output reg [2:0] bit_sel,
  output reg [7:0] wdata,
  input wire [7:0] rdata,
  input wire rvalid,
  input wire bit_value
);
  // Idle at time zero
  initial begin
    op = 3'h0;
    io_addr = 6'h00;
    data_addr = 8'h00;
    bit_sel = 3'h0;
    wdata = 8'h00;
  end
  // One op, answer taken in the cycle after the taking edge
  task automatic issue(input [2:0] o, input [7:0] a, input [2:0] b, input [7:0] w,
                       output [7:0] r, output v, output bv);
    @(negedge clock);
    op = o;
    io_addr = a[5:0];
    data_addr = a;
    bit_sel = b;
    wdata = w;
    @(negedge clock);
    r = rdata;
    v = rvalid;
    bv = bit_value;
    op = 3'h0;
    io_addr = ~io_addr;
    data_addr = ~data_addr;
    bit_sel = ~bit_sel;
    wdata = ~wdata;
  endtask
endmodule // core_model

// ### tb/io_space_register_decoder_tb.sv
// Purpose: self-checking bench for the I/O space decoder
// Assumes: core model drives ops, bench drives pins and events
// Notes: all pins and event pulses driven by the bench
`timescale 1ns/1ps
module io_space_register_decoder_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [7:0] port_a_pins = 8'h00;
  reg [2:0] t0_events = 3'h0;
  reg [3:0] ext_irq_events = 4'h0;
  reg [7:0] port_b_pins = 8'h00;
  reg [1:0] port_d_pins = 2'h0;
  reg [1:0] t1_events = 2'h0;
  reg [1:0] pin_change_events = 2'h0;
  wire [2:0] op, bit_sel;
  wire [5:0] io_addr;
  wire [7:0] data_addr, wdata, rdata, ext_addr, port_a_direction, port_a_output, port_b_direction, port_b_output;
  wire [7:0] port_c_output, port_d_direction, port_d_output, timer0_flags, timer1_flags, pin_change_flags;
  wire [7:0] external_irq_flags, external_irq_mask, eeprom_control, eeprom_data, eeprom_address_low;
  wire [7:0] eeprom_address_high, timer_global_control, timer0_control_a, timer0_control_b, timer0_count;
  wire [7:0] timer0_compare_a, timer0_compare_b, scratch_reg_0, scratch_reg_1, scratch_reg_2;
  wire rvalid, bit_value, ext_access;
  reg [7:0] r;
  reg v, bv;
  integer miscompares = 0;
  integer checks = 0;
  integer cycles = 0;
  io_space_register_decoder io_space_register_decoder_i (.clock, .rst, .op, .io_addr, .data_addr, .bit_sel,
    .wdata, .port_a_pins, .port_b_pins, .port_d_pins, .t0_events, .t1_events,
    .pin_change_events, .ext_irq_events, .rdata, .rvalid, .bit_value, .ext_access, .ext_addr,
    .port_a_direction, .port_a_output, .port_b_direction, .port_b_output, .port_c_output, .port_d_direction,
    .port_d_output, .timer0_flags, .timer1_flags, .pin_change_flags, .external_irq_flags, .external_irq_mask,
    .eeprom_control, .eeprom_data, .eeprom_address_low, .eeprom_address_high, .timer_global_control,
    .timer0_control_a, .timer0_control_b, .timer0_count, .timer0_compare_a, .timer0_compare_b,
    .scratch_reg_0, .scratch_reg_1, .scratch_reg_2);
  core_model core_model_i (.clock, .op, .io_addr, .data_addr, .bit_sel, .wdata, .rdata, .rvalid, .bit_value);
  // Clock and hang guard
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input [7:0] exp, input [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input [2:0] o, input [7:0] a, input [2:0] b, input [7:0] w);
    core_model_i.issue(o, a, b, w, r, v, bv);
  endtask
  // Port A triplet, port B and D pins and one reserved address through both address views
  task automatic t_ports;
    port_a_pins = 8'hA5;
    port_b_pins = 8'hC3;
    port_d_pins = 2'h2;
    go(3'h2, 8'h01, 3'h0, 8'h3C);
    chk("dir_a", 8'h3C, port_a_direction);
    go(3'h3, 8'h21, 3'h0, 8'h00);
    chk("dir_a_data", 8'h3C, r);
    go(3'h4, 8'h22, 3'h0, 8'h5A);
    go(3'h1, 8'h02, 3'h0, 8'h00);
    chk("out_a", 8'h5A, r);
    go(3'h1, 8'h00, 3'h0, 8'h00);
    chk("pins_a", 8'hA5, r);
    go(3'h1, 8'h03, 3'h0, 8'h00);
    chk("pins_b", 8'hC3, r);
    go(3'h3, 8'h29, 3'h0, 8'h00);
    chk("pins_d_data", 8'h02, r);
    go(3'h1, 8'h0C, 3'h0, 8'h00);
    chk("reserved", 8'h00, r);
    $display("ports done");
  endtask
  // Upper window and extended space
  task automatic t_ext;
    go(3'h4, 8'h4B, 3'h0, 8'h66);
    chk("scratch2", 8'h66, scratch_reg_2);
    go(3'h3, 8'h90, 3'h0, 8'h00);
    chk("ext_addr", 8'h90, ext_addr);
    go(3'h1, 8'h20, 3'h0, 8'h00);
    chk("no_ext", 8'h00, {7'h00, ext_access});
    go(3'h4, 8'hC0, 3'h0, 8'h11);
    chk("ext_wr", 8'hC0, ext_addr);
    $display("ext done");
  endtask
  // Flags set by events, cleared by ones and by bit ops
  task automatic t_flags;
    @(negedge clock);
    t0_events = 3'h7;
    ext_irq_events = 4'hF;
    t1_events = 2'h3;
    pin_change_events = 2'h3;
    @(negedge clock);
    t0_events = 3'h0;
    ext_irq_events = 4'h0;
    t1_events = 2'h0;
    pin_change_events = 2'h0;
    chk("t1_set", 8'h03, timer1_flags);
    chk("pc_set", 8'h03, pin_change_flags);
    go(3'h2, 8'h16, 3'h0, 8'h01);
    chk("t1_w1c", 8'h02, timer1_flags);
    go(3'h2, 8'h1B, 3'h0, 8'h03);
    chk("pc_w1c", 8'h00, pin_change_flags);
    go(3'h1, 8'h15, 3'h0, 8'h00);
    chk("t0_flags", 8'h07, r);
    go(3'h2, 8'h15, 3'h0, 8'h02);
    chk("t0_w1c", 8'h05, timer0_flags);
    go(3'h6, 8'h15, 3'h0, 8'h00);
    chk("t0_rmw", 8'h01, timer0_flags);
    go(3'h5, 8'h15, 3'h2, 8'h00);
    chk("t0_set_rmw", 8'h00, timer0_flags);
    go(3'h2, 8'h1C, 3'h0, 8'h0A);
    chk("ext_w1c", 8'h05, external_irq_flags);
    go(3'h5, 8'h1C, 3'h1, 8'h00);
    chk("ext_rmw", 8'h00, external_irq_flags);
    $display("flags done");
  endtask
  // Single-bit set, clear and skip inside the range; set and skip above it
  task automatic t_bits;
    go(3'h2, 8'h1E, 3'h0, 8'h81);
    go(3'h5, 8'h1E, 3'h3, 8'h00);
    chk("set", 8'h89, scratch_reg_0);
    go(3'h6, 8'h1E, 3'h0, 8'h00);
    chk("clr", 8'h88, scratch_reg_0);
    go(3'h7, 8'h1E, 3'h3, 8'h00);
    chk("skip1", 8'h01, {7'h00, bv});
    go(3'h7, 8'h1E, 3'h0, 8'h00);
    chk("skip0", 8'h00, {7'h00, bv});
    go(3'h4, 8'h1E, 3'h0, 8'hFF);
    chk("core_area", 8'h88, scratch_reg_0);
    go(3'h4, 8'h3E, 3'h0, 8'h42);
    chk("scratch0_data", 8'h42, scratch_reg_0);
    go(3'h2, 8'h2A, 3'h0, 8'h10);
    go(3'h5, 8'h2A, 3'h0, 8'h00);
    chk("hi_set", 8'h10, scratch_reg_1);
    go(3'h7, 8'h2A, 3'h4, 8'h00);
    chk("hi_skip", 8'h00, {7'h00, v});
    $display("bits done");
  endtask
  // Remaining registers; only implemented bits are written
  task automatic t_regs;
    go(3'h2, 8'h04, 3'h0, 8'hFF);
    chk("dir_b", 8'hFF, port_b_direction);
    go(3'h2, 8'h05, 3'h0, 8'hC3);
    chk("out_b", 8'hC3, port_b_output);
    go(3'h2, 8'h08, 3'h0, 8'h01);
    chk("out_c", 8'h01, port_c_output);
    go(3'h2, 8'h0A, 3'h0, 8'h03);
    chk("dir_d", 8'h03, port_d_direction);
    go(3'h2, 8'h0B, 3'h0, 8'h02);
    chk("out_d", 8'h02, port_d_output);
    go(3'h2, 8'h1D, 3'h0, 8'h0F);
    chk("ext_mask", 8'h0F, external_irq_mask);
    go(3'h2, 8'h1F, 3'h0, 8'h3F);
    chk("ee_ctrl", 8'h3F, eeprom_control);
    go(3'h4, 8'h40, 3'h0, 8'h5A);
    chk("ee_data", 8'h5A, eeprom_data);
    go(3'h2, 8'h21, 3'h0, 8'hA5);
    chk("ee_lo", 8'hA5, eeprom_address_low);
    go(3'h2, 8'h22, 3'h0, 8'h01);
    chk("ee_hi", 8'h01, eeprom_address_high);
    go(3'h2, 8'h23, 3'h0, 8'h81);
    chk("tgc", 8'h81, timer_global_control);
    go(3'h2, 8'h24, 3'h0, 8'hF3);
    chk("t0_ca", 8'hF3, timer0_control_a);
    go(3'h2, 8'h25, 3'h0, 8'hCF);
    chk("t0_cb", 8'hCF, timer0_control_b);
    go(3'h2, 8'h26, 3'h0, 8'h12);
    chk("t0_cnt", 8'h12, timer0_count);
    go(3'h4, 8'h47, 3'h0, 8'h34);
    chk("t0_cma", 8'h34, timer0_compare_a);
    go(3'h2, 8'h28, 3'h0, 8'h56);
    chk("t0_cmb", 8'h56, timer0_compare_b);
    $display("regs done");
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    t_ports;
    t_ext;
    t_flags;
    t_bits;
    t_regs;
    test_done;
  end
endmodule // io_space_register_decoder_tb
